// *** aobc_pkg.sv ***
package aobc_pkg;

    // register byte offsets on the local bus
    localparam logic [7:0] OFS_OPS = 8'h3c;
    localparam logic [7:0] OFS_THR = 8'h40;
    localparam logic [7:0] OFS_CNT = 8'h44;
    localparam logic [7:0] OFS_WPORT = 8'h48;

    // output_buffer_operations bit positions
    localparam int B_CLK_RDY = 6;
    localparam int B_CIRC = 8;
    localparam int B_LOAD_REQ = 9;
    localparam int B_LOAD_RDY = 10;
    localparam int B_CLEAR = 11;
    localparam int B_EMPTY = 12;
    localparam int B_THR = 13;
    localparam int B_FULL = 15;
    localparam int B_OVR = 16;
    localparam int B_FOVR = 17;
    localparam int B_BURST_RDY = 18;
    localparam int B_BURST_EN = 19;
    localparam int B_SW_FIRE = 20;
    localparam int B_SWAP = 21;

    // output_fifo_threshold flag position, write port marker position
    localparam int B_THR_FLAG = 19;
    localparam int B_EOF = 16;

    // fill count and threshold field width, fifo depth
    localparam int CNT_W = 19;
    localparam int FIFO_DEPTH = 8;

    // values after reset, and the write mask of the misc field
    localparam logic [CNT_W-1:0] THR_RESET = 19'h3fffe;
    localparam logic [7:0] MISC_MASK = 8'h33;
    localparam logic [7:0] MISC_RESET = 8'h03;
    localparam logic DMA_CH_IN_DEF = 1'h0;
    localparam logic DMA_CH_OUT_DEF = 1'h1;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } aobc_bus_req_t;

    typedef struct packed {
        logic eof;
        logic [15:0] data;
    } aobc_sample_t;

endpackage

// *** aobc_top.sv ***
module aobc_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8,
    parameter int CNT_W = 19
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_clear,
    input wire logic i_s_valid,
    output logic o_s_ready,
    input wire logic [WIDTH-1:0] i_s_data,
    output logic o_m_valid,
    input wire logic i_m_ready,
    output logic [WIDTH-1:0] o_m_data,
    output logic [CNT_W-1:0] o_count
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CNT_W-1:0] cnt;
    } aobc_fifo_state_t;

    aobc_fifo_state_t st;
    aobc_fifo_state_t next_st;
    logic do_push;
    logic do_pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == LAST) ? '0 : p + 1'b1;
    endfunction

    // a full fifo still takes a word when one leaves in the same cycle
    assign o_m_valid = (st.cnt != '0);
    assign o_s_ready = (st.cnt != FULL_CNT) | i_m_ready;
    assign o_m_data = st.mem[st.rd];
    assign o_count = st.cnt;
    assign do_push = i_s_valid & o_s_ready;
    assign do_pop = o_m_valid & i_m_ready;

    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.mem[st.wr] = i_s_data;
            next_st.wr = bump(st.wr);
        end
        if (do_pop) begin
            next_st.rd = bump(st.rd);
        end
        if (do_push && !do_pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (do_pop && !do_push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        if (i_clear) begin
            next_st.rd = '0;
            next_st.wr = '0;
            next_st.cnt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// What this block does
// RULE1 - load-request bit asks circular access, self-clears
// RULE2 - load-ready set when frame index wraps
// RULE3 - clear bit empties fifo, then drops
// RULE4 - empty flag high with no values
// RULE5 - full flag high at capacity
// RULE6 - writing full fifo sets overrun error
// RULE7 - writing closed buffer sets frame error
// RULE8 - error bits stay until written low
// RULE9 - burst-ready shows trigger acceptance; else ignored
// RULE10 - burst-enable bit turns on burst, resets low
// RULE11 - software fire gives one trigger, self-clears
// RULE12 - swap bit exchanges demand dma channels
// RULE13 - operations register copies threshold flag
// RULE14 - write word: sample low, marker bit
// RULE15 - write port reads back zero
// RULE16 - fill count reports values held
// RULE17 - threshold field writable, resets 3fffe
// RULE18 - threshold flag when count exceeds threshold
// RULE19 - circular-mode bit selects recirculating buffer
// RULE20 - circular mode writes drained values back
// RULE21 - frame index counts pops, wraps at marker
module aobc_top #(
    parameter int DEPTH = aobc_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire aobc_pkg::aobc_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_bcr_sw_fire,
    input wire logic i_ext_trigger,
    input wire logic i_sample_tick,
    input wire logic i_sample_ready,
    output aobc_pkg::aobc_sample_t o_sample,
    output logic o_sample_valid,
    output logic o_trigger,
    output logic o_write_ready,
    output logic o_in_dma_chan,
    output logic o_out_dma_chan
);
    localparam int CW = aobc_pkg::CNT_W;
    localparam int SW = $bits(aobc_pkg::aobc_sample_t);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [7:0] misc;
        logic circ;
        logic load_req;
        logic load_rdy;
        logic clear;
        logic ovr;
        logic fovr;
        logic burst_en;
        logic sw_fire;
        logic swap;
        logic bursting;
        logic trigger;
        logic [CW-1:0] thr;
        logic [CW-1:0] frame_idx;
        logic [31:0] rdata;
        logic rvalid;
        aobc_pkg::aobc_sample_t smp;
        logic smp_valid;
        logic in_ch;
        logic out_ch;
        logic wr_ready;
    } aobc_top_state_t;

    localparam aobc_top_state_t ST_RESET = '{
        misc: aobc_pkg::MISC_RESET,
        thr: aobc_pkg::THR_RESET,
        in_ch: aobc_pkg::DMA_CH_IN_DEF,
        out_ch: aobc_pkg::DMA_CH_OUT_DEF,
        wr_ready: 1'b1,
        default: '0
    };

    aobc_top_state_t st;
    aobc_top_state_t next_st;

    logic ops_wr;
    logic thr_wr;
    logic port_wr;
    logic closed;
    logic pop;
    logic recirc;
    logic push_valid;
    logic [SW-1:0] push_data;
    logic fifo_s_ready;
    logic fifo_m_valid;
    logic fifo_m_ready;
    logic [SW-1:0] fifo_m_data;
    logic [CW-1:0] cnt;
    aobc_pkg::aobc_sample_t pop_smp;
    aobc_pkg::aobc_sample_t host_smp;
    logic empty;
    logic full;
    logic thr_flag;
    logic burst_rdy;
    logic fire;
    logic [31:0] ops_word;

    assign ops_wr = i_bus.wr && (i_bus.addr == aobc_pkg::OFS_OPS);
    assign thr_wr = i_bus.wr && (i_bus.addr == aobc_pkg::OFS_THR);
    assign port_wr = i_bus.wr && (i_bus.addr == aobc_pkg::OFS_WPORT);
    // upper bits of a write port word are dropped
    assign host_smp = aobc_pkg::aobc_sample_t'(i_bus.wdata[16:0]); // RULE14
    assign closed = st.circ & ~st.load_rdy; // RULE7
    // drain on a sample tick when the output sample is empty or taken and no clear runs; in burst mode only while a frame runs
    assign fifo_m_ready = i_sample_tick & (~st.smp_valid | i_sample_ready)
        & (~st.burst_en | st.bursting) & ~st.clear; // RULE10
    assign pop = fifo_m_valid & fifo_m_ready;
    assign pop_smp = aobc_pkg::aobc_sample_t'(fifo_m_data);
    assign recirc = pop & closed; // RULE20
    assign push_valid = recirc | (port_wr & ~closed & ~st.clear);
    assign push_data = recirc ? fifo_m_data : host_smp; // RULE20
    assign empty = (cnt == '0); // RULE4
    assign full = (cnt == FULL_CNT); // RULE5
    assign thr_flag = (cnt > st.thr); // RULE18
    assign burst_rdy = st.burst_en & ~st.bursting & ~empty & ~st.clear; // RULE9
    assign fire = st.sw_fire | i_bcr_sw_fire | i_ext_trigger;

    aobc_fifo #(
        .WIDTH(SW),
        .DEPTH(DEPTH),
        .CNT_W(CW)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_clear(st.clear), // RULE3
        .i_s_valid(push_valid),
        .o_s_ready(fifo_s_ready),
        .i_s_data(push_data),
        .o_m_valid(fifo_m_valid),
        .i_m_ready(fifo_m_ready),
        .o_m_data(fifo_m_data),
        .o_count(cnt)
    );

    always_comb begin
        ops_word = '0;
        ops_word[7:0] = st.misc;
        ops_word[aobc_pkg::B_CLK_RDY] = 1'b1;
        ops_word[aobc_pkg::B_CIRC] = st.circ;
        ops_word[aobc_pkg::B_LOAD_REQ] = st.load_req;
        ops_word[aobc_pkg::B_LOAD_RDY] = st.load_rdy;
        ops_word[aobc_pkg::B_CLEAR] = st.clear;
        ops_word[aobc_pkg::B_EMPTY] = empty; // RULE4
        ops_word[aobc_pkg::B_THR] = thr_flag; // RULE13
        ops_word[aobc_pkg::B_FULL] = full; // RULE5
        ops_word[aobc_pkg::B_OVR] = st.ovr;
        ops_word[aobc_pkg::B_FOVR] = st.fovr;
        ops_word[aobc_pkg::B_BURST_RDY] = burst_rdy; // RULE9
        ops_word[aobc_pkg::B_BURST_EN] = st.burst_en;
        ops_word[aobc_pkg::B_SW_FIRE] = st.sw_fire;
        ops_word[aobc_pkg::B_SWAP] = st.swap;
    end

    always_comb begin
        next_st = st;
        next_st.clear = 1'b0; // RULE3
        next_st.sw_fire = 1'b0; // RULE11
        next_st.trigger = fire; // RULE11
        if (fire && burst_rdy) begin
            next_st.bursting = 1'b1; // RULE9
        end
        // frame index and end of frame handling
        if (pop) begin
            if (pop_smp.eof) begin
                next_st.frame_idx = '0; // RULE21
                next_st.bursting = 1'b0;
            end else begin
                next_st.frame_idx = st.frame_idx + 1'b1; // RULE21
            end
        end
        if (!st.burst_en) begin
            next_st.bursting = 1'b0;
        end
        if (st.clear) begin
            next_st.frame_idx = '0;
        end
        // loading finishes with the new frame's marker word
        if (port_wr && st.load_rdy && host_smp.eof) begin
            next_st.load_req = 1'b0; // RULE1
            next_st.load_rdy = 1'b0;
        end
        if (ops_wr) begin
            next_st.misc = i_bus.wdata[7:0] & aobc_pkg::MISC_MASK;
            next_st.circ = i_bus.wdata[aobc_pkg::B_CIRC]; // RULE19
            next_st.load_req = i_bus.wdata[aobc_pkg::B_LOAD_REQ]; // RULE1
            next_st.clear = i_bus.wdata[aobc_pkg::B_CLEAR]; // RULE3
            next_st.ovr = i_bus.wdata[aobc_pkg::B_OVR]; // RULE8
            next_st.fovr = i_bus.wdata[aobc_pkg::B_FOVR]; // RULE8
            next_st.burst_en = i_bus.wdata[aobc_pkg::B_BURST_EN]; // RULE10
            next_st.sw_fire = i_bus.wdata[aobc_pkg::B_SW_FIRE]; // RULE11
            next_st.swap = i_bus.wdata[aobc_pkg::B_SWAP]; // RULE12
        end
        if (pop && pop_smp.eof && st.circ && st.load_req) begin
            next_st.load_rdy = 1'b1; // RULE2
        end
        if (!next_st.circ) begin
            next_st.load_rdy = 1'b0;
        end
        if (thr_wr) begin
            next_st.thr = i_bus.wdata[CW-1:0]; // RULE17
        end
        // hardware set wins over a software clear in the same cycle
        if (port_wr && !closed && !fifo_s_ready && !st.clear) begin
            next_st.ovr = 1'b1; // RULE6
        end
        if (port_wr && closed) begin
            next_st.fovr = 1'b1; // RULE7
        end
        next_st.rvalid = i_bus.rd;
        next_st.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                aobc_pkg::OFS_OPS: next_st.rdata = ops_word;
                aobc_pkg::OFS_THR: next_st.rdata = {12'h000, thr_flag, st.thr};
                aobc_pkg::OFS_CNT: next_st.rdata = {13'h0000, cnt}; // RULE16
                aobc_pkg::OFS_WPORT: next_st.rdata = '0; // RULE15
                default: next_st.rdata = '0;
            endcase
        end
        if (pop) begin
            next_st.smp = pop_smp;
            next_st.smp_valid = 1'b1;
        end else if (i_sample_ready) begin
            next_st.smp_valid = 1'b0;
        end
        next_st.in_ch = st.swap ? aobc_pkg::DMA_CH_OUT_DEF
                                : aobc_pkg::DMA_CH_IN_DEF; // RULE12
        next_st.out_ch = st.swap ? aobc_pkg::DMA_CH_IN_DEF
                                 : aobc_pkg::DMA_CH_OUT_DEF; // RULE12
        next_st.wr_ready = ~closed & ~full;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_rvalid = st.rvalid;
    assign o_sample = st.smp;
    assign o_sample_valid = st.smp_valid;
    assign o_trigger = st.trigger;
    assign o_write_ready = st.wr_ready;
    assign o_in_dma_chan = st.in_ch;
    assign o_out_dma_chan = st.out_ch;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_clear_empties: assert property ( // RULE3
        st.clear && !ops_wr |=> (cnt == '0) && !st.clear)
        else $error("clear did not empty the fifo");
    a_empty_read: assert property ( // RULE4
        i_bus.rd && i_bus.addr == aobc_pkg::OFS_OPS
        |=> o_rvalid && (o_rdata[aobc_pkg::B_EMPTY] == ($past(cnt) == '0)))
        else $error("empty flag wrong on read");
    a_full_read: assert property ( // RULE5
        i_bus.rd && i_bus.addr == aobc_pkg::OFS_OPS
        |=> o_rdata[aobc_pkg::B_FULL] == ($past(cnt) == FULL_CNT))
        else $error("full flag wrong on read");
    a_overrun_set: assert property ( // RULE6
        port_wr && !closed && !fifo_s_ready && !st.clear |=> st.ovr)
        else $error("overrun error not set");
    a_frame_err_set: assert property ( // RULE7
        port_wr && closed |=> st.fovr)
        else $error("frame error not set");
    a_errors_sticky: assert property ( // RULE8
        st.ovr && !ops_wr |=> st.ovr)
        else $error("overrun error dropped without a write");
    a_fire_once: assert property ( // RULE11
        st.sw_fire && !ops_wr |=> o_trigger && !st.sw_fire)
        else $error("software fire did not give one trigger");
    a_port_reads_zero: assert property ( // RULE15
        i_bus.rd && i_bus.addr == aobc_pkg::OFS_WPORT
        |=> o_rvalid && o_rdata == 32'h00000000)
        else $error("write port read not zero");
    a_count_read: assert property ( // RULE16
        i_bus.rd && i_bus.addr == aobc_pkg::OFS_CNT
        |=> o_rdata == {13'h0000, $past(cnt)})
        else $error("fill count read wrong");
    a_thr_flag_read: assert property ( // RULE18
        i_bus.rd && i_bus.addr == aobc_pkg::OFS_THR
        |=> o_rdata[aobc_pkg::B_THR_FLAG] == ($past(cnt) > $past(st.thr)))
        else $error("threshold flag wrong");
    a_load_rdy_set: assert property ( // RULE2
        pop && pop_smp.eof && st.circ && st.load_req && !ops_wr
        |=> st.load_rdy)
        else $error("load ready not set at frame wrap");
    a_swap_dma: assert property ( // RULE12
        st.swap ##1 st.swap |=> o_in_dma_chan == aobc_pkg::DMA_CH_OUT_DEF
        && o_out_dma_chan == aobc_pkg::DMA_CH_IN_DEF)
        else $error("dma channels not swapped");
    a_frame_wrap: assert property ( // RULE21
        pop && pop_smp.eof |=> st.frame_idx == '0)
        else $error("frame index did not return to zero");
endmodule

// *** aobc_host.sv ***
module aobc_host (
    input wire logic i_clk,
    output aobc_pkg::aobc_bus_req_t o_bus
);
    timeunit 1ns;
    timeprecision 1ns;

    initial o_bus = '0;

    // one access per call, held over exactly one sampling edge
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        @(posedge i_clk);
        #10;
        o_bus.wr = w;
        o_bus.rd = !w;
        o_bus.addr = a;
        o_bus.wdata = d;
        @(posedge i_clk);
        #10;
        o_bus.wr = 1'b0;
        o_bus.rd = 1'b0;
        o_bus.addr = ~a;
        o_bus.wdata = ~d;
    endtask
endmodule

// *** tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] M = 32'hffffffff;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_bcr_sw_fire = 1'b0;
    logic i_ext_trigger = 1'b0;
    logic i_sample_tick = 1'b0;
    logic i_sample_ready = 1'b0;
    aobc_pkg::aobc_bus_req_t bus;
    aobc_pkg::aobc_sample_t o_sample;
    logic [31:0] o_rdata;
    logic o_rvalid, o_sample_valid, o_trigger, o_write_ready;
    logic o_in_dma_chan, o_out_dma_chan;
    logic [63:0] rq[$];
    aobc_pkg::aobc_sample_t sq[$];
    aobc_pkg::aobc_sample_t held[$];
    logic [63:0] cur;
    integer seed = 32'h8e9fd63b;
    int bad_count = 0;
    int checked = 0;
    int trig_n = 0;
    int cycles = 0;
    int n0;

    always #50 i_clk = ~i_clk;

    aobc_host u_host (.i_clk(i_clk), .o_bus(bus));

    aobc_top #(.DEPTH(8)) u_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .i_bcr_sw_fire(i_bcr_sw_fire),
        .i_ext_trigger(i_ext_trigger), .i_sample_tick(i_sample_tick),
        .i_sample_ready(i_sample_ready), .o_sample(o_sample),
        .o_sample_valid(o_sample_valid), .o_trigger(o_trigger),
        .o_write_ready(o_write_ready), .o_in_dma_chan(o_in_dma_chan),
        .o_out_dma_chan(o_out_dma_chan)
    );

    function automatic logic [31:0] bm(input int b);
        return 32'h1 << b;
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.access(1'b1, a, d);
    endtask

    // note the expected masked value, then issue the read
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        rq.push_back({m, e});
        u_host.access(1'b0, a, 32'h0);
    endtask

    // random sample, random upper bits that must be ignored
    task automatic put_word(input logic eof, input logic keep);
        aobc_pkg::aobc_sample_t s;
        logic [31:0] r;
        r = $random(seed);
        s.eof = eof;
        s.data = r[15:0];
        if (keep) held.push_back(s);
        wr(aobc_pkg::OFS_WPORT, {r[31:17], eof, r[15:0]});
    endtask

    task automatic tick(input logic take, input logic recirc);
        aobc_pkg::aobc_sample_t s;
        if (take) begin
            s = held.pop_front();
            sq.push_back(s);
            if (recirc) held.push_back(s);
        end
        @(posedge i_clk);
        #10;
        i_sample_tick = 1'b1;
        @(posedge i_clk);
        #10;
        i_sample_tick = 1'b0;
    endtask

    task automatic pulse(input logic board_control_reg, input logic ext);
        @(posedge i_clk);
        #10;
        i_bcr_sw_fire = board_control_reg;
        i_ext_trigger = ext;
        @(posedge i_clk);
        #10;
        i_bcr_sw_fire = 1'b0;
        i_ext_trigger = 1'b0;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (o_trigger === 1'b1) trig_n++;
        if (o_rvalid === 1'b1) begin
            if (rq.size() > 0) begin
                cur = rq.pop_front();
                check("read data", o_rdata & cur[63:32], cur[31:0]);
            end else begin
                check("unasked read", 32'h1, 32'h0);
            end
        end
        if (o_sample_valid === 1'b1 && i_sample_ready === 1'b1) begin
            if (sq.size() > 0) begin
                check("sample", {15'h0, o_sample}, {15'h0, sq.pop_front()});
            end else begin
                check("unasked sample", 32'h1, 32'h0);
            end
        end
        if (cycles == 3000) begin
            check("timeout", 32'h1, 32'h0);
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge i_clk);
        #10;
        i_srst = 1'b0;
        i_sample_ready = 1'b1;
        check("dma in", {31'h0, o_in_dma_chan}, 32'h0);
        check("dma out", {31'h0, o_out_dma_chan}, 32'h1);
        check("write ready", {31'h0, o_write_ready}, 32'h1);
        rd(aobc_pkg::OFS_OPS, M, 32'h00001043);
        rd(aobc_pkg::OFS_THR, M, 32'h0003fffe);
        rd(aobc_pkg::OFS_CNT, M, 32'h0);
        rd(aobc_pkg::OFS_WPORT, M, 32'h0);
        rd(8'h50, M, 32'h0);
        $display("test reset values done");

        wr(aobc_pkg::OFS_THR, 32'hfff80003);
        rd(aobc_pkg::OFS_THR, M, 32'h3);
        repeat (3) put_word(1'b0, 1'b1);
        rd(aobc_pkg::OFS_THR, M, 32'h3);
        put_word(1'b0, 1'b1);
        rd(aobc_pkg::OFS_THR, M, 32'h00080003);
        rd(aobc_pkg::OFS_OPS, bm(13), bm(13));
        for (int i = 0; i < 4; i++) put_word(i == 3, 1'b1);
        rd(aobc_pkg::OFS_CNT, M, 32'h8);
        check("write ready", {31'h0, o_write_ready}, 32'h0);
        rd(aobc_pkg::OFS_OPS, M, 32'h0000a043);
        put_word(1'b0, 1'b0);
        rd(aobc_pkg::OFS_CNT, M, 32'h8);
        rd(aobc_pkg::OFS_OPS, bm(16), bm(16));
        rd(aobc_pkg::OFS_OPS, bm(16), bm(16));
        wr(aobc_pkg::OFS_OPS, 32'h3);
        rd(aobc_pkg::OFS_OPS, bm(16), 32'h0);
        repeat (8) tick(1'b1, 1'b0);
        idle(2);
        rd(aobc_pkg::OFS_OPS, M, 32'h00001043);
        check("write ready", {31'h0, o_write_ready}, 32'h1);
        rd(aobc_pkg::OFS_CNT, M, 32'h0);
        $display("test fill and drain done");

        repeat (3) put_word(1'b0, 1'b0);
        rd(aobc_pkg::OFS_CNT, M, 32'h3);
        wr(aobc_pkg::OFS_OPS, 32'h3 | bm(11));
        idle(3);
        rd(aobc_pkg::OFS_OPS, bm(11) | bm(12), bm(12));
        rd(aobc_pkg::OFS_CNT, M, 32'h0);
        $display("test clear done");

        wr(aobc_pkg::OFS_OPS, 32'h103);
        put_word(1'b0, 1'b0);
        rd(aobc_pkg::OFS_CNT, M, 32'h0);
        rd(aobc_pkg::OFS_OPS, M, 32'h00021143);
        check("write ready", {31'h0, o_write_ready}, 32'h0);
        wr(aobc_pkg::OFS_OPS, 32'h3);
        rd(aobc_pkg::OFS_OPS, bm(17), 32'h0);
        put_word(1'b0, 1'b1);
        put_word(1'b1, 1'b1);
        wr(aobc_pkg::OFS_OPS, 32'h103);
        tick(1'b1, 1'b1);
        tick(1'b1, 1'b1);
        idle(2);
        rd(aobc_pkg::OFS_CNT, M, 32'h2);
        wr(aobc_pkg::OFS_OPS, 32'h303);
        tick(1'b1, 1'b1);
        tick(1'b1, 1'b1);
        idle(2);
        rd(aobc_pkg::OFS_OPS, bm(9) | bm(10), bm(9) | bm(10));
        put_word(1'b1, 1'b0);
        rd(aobc_pkg::OFS_CNT, M, 32'h3);
        rd(aobc_pkg::OFS_OPS, bm(9) | bm(17), 32'h0);
        wr(aobc_pkg::OFS_OPS, 32'h3 | bm(11));
        held.delete();
        idle(3);
        $display("test circular done");

        for (int k = 0; k < 3; k++) begin
            n0 = trig_n;
            if (k == 0) wr(aobc_pkg::OFS_OPS, 32'h3 | bm(20));
            pulse(k == 1, k == 2);
            idle(4);
            check("trigger count", 32'(trig_n - n0), 32'h1);
        end
        rd(aobc_pkg::OFS_OPS, bm(20), 32'h0);
        $display("test triggers done");

        wr(aobc_pkg::OFS_OPS, 32'h3 | bm(19));
        rd(aobc_pkg::OFS_OPS, bm(18) | bm(19), bm(19));
        put_word(1'b0, 1'b1);
        put_word(1'b1, 1'b1);
        idle(2);
        rd(aobc_pkg::OFS_OPS, bm(18), bm(18));
        tick(1'b0, 1'b0);
        idle(2);
        rd(aobc_pkg::OFS_CNT, M, 32'h2);
        pulse(1'b0, 1'b1);
        idle(2);
        tick(1'b1, 1'b0);
        tick(1'b1, 1'b0);
        idle(2);
        rd(aobc_pkg::OFS_CNT, M, 32'h0);
        $display("test burst done");

        wr(aobc_pkg::OFS_OPS, 32'hb3 | bm(21));
        rd(aobc_pkg::OFS_OPS, 32'h002000ff, 32'h00200073);
        idle(3);
        check("dma in", {31'h0, o_in_dma_chan}, 32'h1);
        check("dma out", {31'h0, o_out_dma_chan}, 32'h0);
        $display("test swap done");
        idle(4);
        wrap_up();
    end
endmodule
